// *** scte_top.sv ***
// Stream clock selection, trigger start/stop and fast event lines
//
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "scte_params.svh"
module scte_top (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        input_stream_clock_pin_in,
  output logic             input_stream_clock_pin_out,
  output logic             input_stream_clock_pin_oe,
  input  wire logic        output_stream_clock_pin_in,
  output logic             output_stream_clock_pin_out,
  output logic             output_stream_clock_pin_oe,
  input  wire logic        fast_event_line_one,
  input  wire logic        fast_event_line_two,
  input  wire logic        fast_event_line_three,
  input  wire logic        fast_event_line_four,
  input  wire logic [15:0] dio_in,
  output logic [15:0]      dio_out,
  output logic             in_sample_pulse,
  output logic             out_update_pulse,
  output logic             trigger_event,
  output logic             host_irq
);

  scte_pkg::scte_state_t       r;
  scte_pkg::scte_state_t       n;
  scte_pkg::scte_src_t [1:0]   src;
  logic [`SCTE_SYNC_N-1:0]     raw;
  logic [`SCTE_SYNC_N-1:0]     lvl;
  logic [`SCTE_SYNC_N-1:0]     fall;
  logic [1:0]                  pin_fall;
  logic [3:0]                  line_fall;
  logic [15:0]                 din;
  logic                        trig_fall;
  logic [1:0]                  tick;
  logic                        wr_go;
  logic [5:0]                  cmd;
  logic [3:0]                  pend_clr;
  logic [31:0]                 rword;
  logic [31:0]                 wword;

  // External clock wins over trigger, trigger over software, else timer
  function automatic scte_pkg::scte_src_t decode_src(
    input logic [`SCTE_CFG_W-1:0] cfg
  );
    if (cfg[`SCTE_CFG_EXT]) begin
      return scte_pkg::SCTE_SRC_EXT;
    end else if (cfg[`SCTE_CFG_TRIG]) begin
      return scte_pkg::SCTE_SRC_TRIG;
    end else if (cfg[`SCTE_CFG_SW]) begin
      return scte_pkg::SCTE_SRC_SW;
    end
    return scte_pkg::SCTE_SRC_INT;
  endfunction : decode_src

  function automatic logic [31:0] be_merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0]  be
  );
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return res;
  endfunction : be_merge

  assign raw = {dio_in,
                fast_event_line_four,
                fast_event_line_three,
                fast_event_line_two,
                fast_event_line_one,
                output_stream_clock_pin_in,
                input_stream_clock_pin_in};

  for (genvar g = 0; g < `SCTE_SYNC_N; g++) begin : g_sync
    scte_sync u_sync (
      .clk      (clk),
      .rstn     (rstn),
      .async_in (raw[g]),
      .level    (lvl[g]),
      .fall     (fall[g])
    );
  end

  // Pins pass the synchroniser; sampling at 40 ns bounds the shortest pulse seen
  assign pin_fall  = fall[1:0];
  assign line_fall = fall[5:2];
  assign din       = lvl[21:6];
  assign trig_fall = line_fall[`SCTE_TRIG_LINE];

  always_comb begin
    n        = r;
    src      = {2{scte_pkg::SCTE_SRC_INT}};
    tick     = 2'b00;
    wr_go    = avs_write && r.wait_req;
    cmd      = 6'h00;
    pend_clr = 4'h0;

    case (avs_address)
      `SCTE_OFS_CFG_IN:    rword = {27'h0, r.st[0].cfg};
      `SCTE_OFS_CFG_OUT:   rword = {27'h0, r.st[1].cfg};
      `SCTE_OFS_DIV_IN:    rword = {16'h0, r.st[0].div};
      `SCTE_OFS_DIV_OUT:   rword = {16'h0, r.st[1].div};
      `SCTE_OFS_STATUS:    rword = {26'h0, r.st[1].run, r.st[0].run};
      `SCTE_OFS_IN_DATA:   rword = {16'h0, r.in_data};
      `SCTE_OFS_OUT_DATA:  rword = {16'h0, r.out_data};
      `SCTE_OFS_FAST_EN:   rword = {28'h0, r.fast_en};
      `SCTE_OFS_FAST_PEND: rword = {28'h0, r.fast_pend};
      default:             rword = 32'h0;
    endcase
    wword = be_merge(rword, avs_writedata, avs_byteenable);

    n.in_pulse   = 1'b0;
    n.out_pulse  = 1'b0;
    n.trig_pulse = trig_fall;

    // One wait cycle per access, then a cycle with waitrequest low
    n.wait_req = 1'b1;
    if (r.wait_req && (avs_read || avs_write)) begin
      n.wait_req = 1'b0;
      n.rdata    = avs_read ? rword : 32'h0;
    end

    if (wr_go) begin
      case (avs_address)
        `SCTE_OFS_CFG_IN: begin
          n.st[0].cfg = wword[`SCTE_CFG_W-1:0];
        end
        `SCTE_OFS_CFG_OUT: begin
          n.st[1].cfg = wword[`SCTE_CFG_W-1:0];
        end
        `SCTE_OFS_DIV_IN: begin
          n.st[0].div = wword[15:0];
        end
        `SCTE_OFS_DIV_OUT: begin
          n.st[1].div = wword[15:0];
        end
        `SCTE_OFS_CMD: begin
          cmd = avs_writedata[5:0] & {6{avs_byteenable[0]}};
        end
        `SCTE_OFS_OUT_DATA: begin
          n.out_data = wword[15:0];
        end
        `SCTE_OFS_FAST_EN: begin
          n.fast_en = wword[3:0];
        end
        `SCTE_OFS_FAST_PEND: begin
          pend_clr = avs_writedata[3:0] & {4{avs_byteenable[0]}};
        end
        default: begin
        end
      endcase
    end

    for (int i = 0; i < 2; i++) begin
      src[i]      = decode_src(r.st[i].cfg);
      n.st[i].cnt = 16'h0000;
      // Ticks count only while running
      if (r.st[i].run == scte_pkg::SCTE_RUN) begin
        case (src[i])
          scte_pkg::SCTE_SRC_INT: begin
            tick[i]     = (r.st[i].cnt >= r.st[i].div);
            n.st[i].cnt = tick[i] ? 16'h0000 : r.st[i].cnt + 16'h0001;
          end
          scte_pkg::SCTE_SRC_EXT: begin
            tick[i] = pin_fall[i];
          end
          scte_pkg::SCTE_SRC_SW: begin
            tick[i] = cmd[`SCTE_CMD_SWCLK + i];
          end
          scte_pkg::SCTE_SRC_TRIG: begin
            tick[i] = trig_fall && !r.st[i].cfg[`SCTE_CFG_STOP];
          end
          default: begin
            tick[i] = 1'b0;
          end
        endcase
      end

      case (r.st[i].run)
        scte_pkg::SCTE_IDLE: begin
          if (cmd[`SCTE_CMD_START + i]) begin
            n.st[i].run = r.st[i].cfg[`SCTE_CFG_START] ? scte_pkg::SCTE_ARMED
                                                       : scte_pkg::SCTE_RUN;
          end
        end
        scte_pkg::SCTE_ARMED: begin
          if (trig_fall) begin
            n.st[i].run = scte_pkg::SCTE_RUN;
          end
        end
        scte_pkg::SCTE_RUN: begin
          if (r.st[i].cfg[`SCTE_CFG_STOP] && trig_fall) begin
            n.st[i].run = r.st[i].cfg[`SCTE_CFG_START] ? scte_pkg::SCTE_ARMED
                                                       : scte_pkg::SCTE_IDLE;
          end
        end
        default: begin
          n.st[i].run = scte_pkg::SCTE_IDLE;
        end
      endcase
      if (cmd[`SCTE_CMD_STOP + i]) begin
        n.st[i].run = scte_pkg::SCTE_IDLE;
      end

      // Timer mode exports a one-cycle low pulse per tick
      n.pin_oe[i]  = (src[i] == scte_pkg::SCTE_SRC_INT);
      n.pin_out[i] = !(tick[i] && (src[i] == scte_pkg::SCTE_SRC_INT));
    end

    if (tick[0]) begin
      n.in_data  = din;
      n.in_pulse = 1'b1;
    end
    if (tick[1]) begin
      n.dio_out   = r.out_data;
      n.out_pulse = 1'b1;
    end

    // A new event wins over a clear in the same cycle
    n.fast_pend = (r.fast_pend & ~pend_clr) | (line_fall & r.fast_en);
    n.host_irq  = |(n.fast_pend & n.fast_en);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r           <= '0;
      r.st[0].cfg <= `SCTE_CFG_RST;
      r.st[1].cfg <= `SCTE_CFG_RST;
      r.st[0].div <= `SCTE_DIV_RST;
      r.st[1].div <= `SCTE_DIV_RST;
      r.st[0].run <= scte_pkg::SCTE_IDLE;
      r.st[1].run <= scte_pkg::SCTE_IDLE;
      r.pin_out   <= 2'b11;
      r.pin_oe    <= 2'b11;
      r.wait_req  <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign avs_readdata                = r.rdata;
  assign avs_waitrequest             = r.wait_req;
  assign input_stream_clock_pin_out  = r.pin_out[0];
  assign input_stream_clock_pin_oe   = r.pin_oe[0];
  assign output_stream_clock_pin_out = r.pin_out[1];
  assign output_stream_clock_pin_oe  = r.pin_oe[1];
  assign dio_out                     = r.dio_out;
  assign in_sample_pulse             = r.in_pulse;
  assign out_update_pulse            = r.out_pulse;
  assign trigger_event               = r.trig_pulse;
  assign host_irq                    = r.host_irq;

  // Interrupt latency bound in clock cycles, for the delay range below
  localparam int IRQ_LAT_CYC = `SCTE_IRQ_LAT_CYC;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_irq_latency: assert property (
    (|(line_fall & r.fast_en)) && !wr_go |-> ##[1:IRQ_LAT_CYC] r.host_irq
  ) else $error("host interrupt late after fast event");

  a_pend_hold: assert property (
    r.fast_pend[0] && !pend_clr[0] |=> r.fast_pend[0]
  ) else $error("fast event latch lost");

  a_irq_enable: assert property (
    !wr_go && (r.fast_en == 4'h0) |=> !r.host_irq
  ) else $error("interrupt raised with all lines disabled");

  a_trig_start: assert property (
    r.st[0].run == scte_pkg::SCTE_ARMED && trig_fall && !cmd[`SCTE_CMD_STOP]
    |=> r.st[0].run == scte_pkg::SCTE_RUN
  ) else $error("trigger did not start stream");

  a_trig_stop: assert property (
    r.st[0].run == scte_pkg::SCTE_RUN && r.st[0].cfg[`SCTE_CFG_STOP] && trig_fall
    |=> r.st[0].run != scte_pkg::SCTE_RUN ##1 !r.in_pulse
  ) else $error("trigger did not stop stream");

  a_no_tick_idle: assert property (
    r.st[1].run != scte_pkg::SCTE_RUN |=> !r.out_pulse
  ) else $error("output updated while stream stopped");

  a_sample_val: assert property (
    tick[0] |=> r.in_pulse && (r.in_data == $past(din))
  ) else $error("input sample not captured");

  a_out_val: assert property (
    tick[1] |=> r.out_pulse && (dio_out == $past(r.out_data))
  ) else $error("output port not updated");

  a_ext_tick: assert property (
    decode_src(r.st[0].cfg) == scte_pkg::SCTE_SRC_EXT &&
    r.st[0].run == scte_pkg::SCTE_RUN && pin_fall[0] |=> r.in_pulse
  ) else $error("external clock edge missed");

  a_ext_undriven: assert property (
    !wr_go && decode_src(r.st[0].cfg) != scte_pkg::SCTE_SRC_INT |=> !r.pin_oe[0]
  ) else $error("timer pin driven outside timer mode");

  a_export_pulse: assert property (
    tick[0] && decode_src(r.st[0].cfg) == scte_pkg::SCTE_SRC_INT
    |=> !r.pin_out[0] && r.pin_oe[0]
  ) else $error("internal clock not exported");

  a_bus_wait: assert property (
    (avs_read || avs_write) && r.wait_req |=> !r.wait_req ##1 r.wait_req
  ) else $error("waitrequest sequence broken");

endmodule : scte_top
`default_nettype wire

// *** scte_params.svh ***
// Constants for the stream clock and trigger control block
`ifndef SCTE_PARAMS_SVH
`define SCTE_PARAMS_SVH

`define SCTE_ADDR_W        6
`define SCTE_OFS_CFG_IN    6'h00
`define SCTE_OFS_CFG_OUT   6'h04
`define SCTE_OFS_DIV_IN    6'h08
`define SCTE_OFS_DIV_OUT   6'h0c
`define SCTE_OFS_CMD       6'h10
`define SCTE_OFS_STATUS    6'h14
`define SCTE_OFS_IN_DATA   6'h18
`define SCTE_OFS_OUT_DATA  6'h1c
`define SCTE_OFS_FAST_EN   6'h20
`define SCTE_OFS_FAST_PEND 6'h24

`define SCTE_CFG_EXT       0
`define SCTE_CFG_SW        1
`define SCTE_CFG_TRIG      2
`define SCTE_CFG_START     3
`define SCTE_CFG_STOP      4
`define SCTE_CFG_W         5
`define SCTE_CFG_RST       5'h00
`define SCTE_DIV_RST       16'h0018

`define SCTE_CMD_START     0
`define SCTE_CMD_STOP      2
`define SCTE_CMD_SWCLK     4

`define SCTE_TRIG_LINE     2
`define SCTE_SYNC_N        22

`define SCTE_CLK_NS        40
`define SCTE_IRQ_LAT_NS    100
`define SCTE_IRQ_LAT_CYC   (`SCTE_IRQ_LAT_NS / `SCTE_CLK_NS)

`endif

// *** scte_pkg.sv ***
// Types shared by the stream clock and trigger control block
`include "scte_params.svh"
package scte_pkg;

  typedef enum logic [2:0] {
    SCTE_IDLE  = 3'b001,
    SCTE_ARMED = 3'b010,
    SCTE_RUN   = 3'b100
  } scte_run_t;

  typedef enum logic [3:0] {
    SCTE_SRC_INT  = 4'b0001,
    SCTE_SRC_EXT  = 4'b0010,
    SCTE_SRC_SW   = 4'b0100,
    SCTE_SRC_TRIG = 4'b1000
  } scte_src_t;

  typedef struct packed {
    logic [`SCTE_CFG_W-1:0] cfg;
    logic [15:0]            div;
    logic [15:0]            cnt;
    scte_run_t              run;
  } scte_stream_t;

  typedef struct packed {
    scte_stream_t [1:0] st;
    logic [15:0]        in_data;
    logic [15:0]        out_data;
    logic [15:0]        dio_out;
    logic [3:0]         fast_en;
    logic [3:0]         fast_pend;
    logic               host_irq;
    logic [1:0]         pin_out;
    logic [1:0]         pin_oe;
    logic               in_pulse;
    logic               out_pulse;
    logic               trig_pulse;
    logic               wait_req;
    logic [31:0]        rdata;
  } scte_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } scte_sync_t;

endpackage : scte_pkg

// *** scte_sync.sv ***
// Two-stage synchroniser with falling-edge detection
`timescale 1ns/1ps
`default_nettype none
module scte_sync (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic async_in,
  output logic      level,
  output logic      fall
);
  scte_pkg::scte_sync_t r;
  scte_pkg::scte_sync_t n;

  always_comb begin
    n    = r;
    n.s1 = async_in;
    n.s2 = r.s1;
    n.s3 = r.s2;
  end

  // Idle-high reset keeps a line from showing a false edge at release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= 3'b111;
    end else begin
      r <= n;
    end
  end

  assign level = r.s2;
  assign fall  = r.s3 & ~r.s2;
endmodule : scte_sync
`default_nettype wire

// *** scte_far_model.sv ***
// Far-side user hardware: external stream clocks and fast event lines
`timescale 1ns/1ps
`default_nettype none
module scte_far_model (
  output logic       in_clk_drv,
  output logic       out_clk_drv,
  output logic [3:0] line_drv
);
  localparam int LINK_HALF_NS = 160; // Rate set by the bench link period
  initial begin
    in_clk_drv  = 1'b1;
    out_clk_drv = 1'b1;
    line_drv    = 4'b1001; // Boot-safe levels on the fast lines
  end
  task automatic boot_done();
    line_drv = 4'hf;
  endtask : boot_done
  // Burst of active-low pulses on one timer pin, idle high between bursts
  // Acts as the master clock that a slave set to external clock follows
  task automatic clk_pulses(input logic sel_out, input int n);
    for (int i = 0; i < n; i++) begin
      in_clk_drv  = sel_out;
      out_clk_drv = !sel_out;
      #(LINK_HALF_NS);
      in_clk_drv  = 1'b1;
      out_clk_drv = 1'b1;
      #(LINK_HALF_NS);
    end
  endtask : clk_pulses
  // Low pulse on a fast line, then a quiet gap before the next one
  task automatic pulse_line(input int idx, input int low_ns, input int gap_ns);
    line_drv[idx] = 1'b0;
    #(low_ns);
    line_drv[idx] = 1'b1;
    #(gap_ns);
  endtask : pulse_line
endmodule : scte_far_model
`default_nettype wire

// *** test_scte_top.sv ***
// Self-checking bench for the stream clock and trigger control block
`timescale 1ns/1ps
`default_nettype none
module test_scte_top;
  typedef struct packed {
    logic        w;
    logic [5:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } scte_row_t;
  localparam int N_ROWS = 15;
  localparam scte_row_t ROWS [N_ROWS] = '{
    '{1'b0, 6'h00, 32'h0, 32'h0}, '{1'b0, 6'h04, 32'h0, 32'h0}, '{1'b0, 6'h08, 32'h0, 32'h18},
    '{1'b0, 6'h0c, 32'h0, 32'h18}, '{1'b0, 6'h10, 32'h0, 32'h0}, '{1'b0, 6'h14, 32'h0, 32'h9},
    '{1'b0, 6'h20, 32'h0, 32'h0}, '{1'b0, 6'h24, 32'h0, 32'h0}, '{1'b0, 6'h28, 32'h0, 32'h0},
    '{1'b1, 6'h00, 32'hff, 32'h1f}, '{1'b1, 6'h00, 32'h0, 32'h0},
    '{1'b1, 6'h08, 32'hffff1234, 32'h1234}, '{1'b1, 6'h20, 32'hff, 32'hf},
    '{1'b1, 6'h28, 32'hff, 32'h0}, '{1'b1, 6'h20, 32'h0, 32'h0}};
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [5:0]  addr = 6'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] q;
  logic        wait_req;
  logic        t1o, t1e, t2o, t2e, m1, m2;
  wire         t1 = t1e ? t1o : m1;
  wire         t2 = t2e ? t2o : m2;
  logic [3:0]  ln;
  logic [15:0] din = 16'h1234;
  logic [15:0] dout;
  logic        isp, oup, tev, irq;
  logic [15:0] cnt [2] = '{16'h0, 16'h0};
  logic [15:0] trg_cnt = 16'h0;
  logic [15:0] n, m;
  int          bad_count = 0;
  int          tests_run = 0;

  scte_top i_dut (
    .clk(clk), .rstn(rstn), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(rdata),
    .avs_waitrequest(wait_req), .input_stream_clock_pin_in(t1),
    .input_stream_clock_pin_out(t1o), .input_stream_clock_pin_oe(t1e),
    .output_stream_clock_pin_in(t2), .output_stream_clock_pin_out(t2o),
    .output_stream_clock_pin_oe(t2e), .fast_event_line_one(ln[0]),
    .fast_event_line_two(ln[1]), .fast_event_line_three(ln[2]),
    .fast_event_line_four(ln[3]), .dio_in(din), .dio_out(dout), .in_sample_pulse(isp),
    .out_update_pulse(oup), .trigger_event(tev), .host_irq(irq));
  scte_far_model far (.in_clk_drv(m1), .out_clk_drv(m2), .line_drv(ln));

  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (isp === 1'b1) cnt[0] <= cnt[0] + 16'h1;
    if (oup === 1'b1) cnt[1] <= cnt[1] + 16'h1;
    if (tev === 1'b1) trg_cnt <= trg_cnt + 16'h1;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      if (wait_req === 1'b0) break;
    end
    chk(32'(wait_req), 32'h0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic wait_hi(input int s);
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      if ((s == 0 ? isp : oup) === 1'b1) break;
    end
  endtask : wait_hi
  task automatic complete_run();
    if (bad_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  initial begin
    #(200_000);
    bad_count++;
    $display("[FAIL] t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
    complete_run();
  end

  initial begin
    repeat (4) @(posedge clk);
    chk(32'({wait_req, t1o, t1e, t2o, t2e, irq, dout}), 32'h3e_0000);
    rstn <= 1'b1;
    far.boot_done();
    for (int i = 0; i < N_ROWS; i++) begin
      if (ROWS[i].w) bus(1'b1, ROWS[i].a, ROWS[i].d);
      bus(1'b0, ROWS[i].a, 32'h0);
      chk(q, ROWS[i].e);
    end
    bus(1'b1, 6'h08, 32'h1);
    bus(1'b1, 6'h10, 32'h1);
    wait_hi(0);
    chk(32'({isp, t1o, t1e}), 32'h5);
    @(posedge clk);
    chk(32'(isp), 32'h0);
    @(posedge clk);
    chk(32'(isp), 32'h1);
    bus(1'b0, 6'h18, 32'h0);
    chk(q, 32'h1234);
    bus(1'b1, 6'h1c, 32'ha5c3);
    bus(1'b1, 6'h0c, 32'h0);
    bus(1'b1, 6'h10, 32'h2);
    wait_hi(1);
    chk(32'({dout, t2o, t2e}), {14'h0, 16'ha5c3, 2'b01});
    bus(1'b1, 6'h10, 32'hc);
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, 6'(4 * s), 32'h1);
      n = cnt[s];
      far.clk_pulses(1'(s), 2);
      bus(1'b1, 6'h10, 32'h1 << s);
      far.clk_pulses(1'(s), 3);
      repeat (4) @(posedge clk);
      chk(32'(cnt[s] - n), 32'h3);
    end
    chk(32'({t1e, t2e}), 32'h0);
    bus(1'b1, 6'h10, 32'hc);
    bus(1'b1, 6'h00, 32'h19);
    bus(1'b1, 6'h10, 32'h1);
    bus(1'b0, 6'h14, 32'h0);
    chk(32'(q[2:0]), 32'h2);
    n = cnt[0];
    m = trg_cnt;
    far.clk_pulses(1'b0, 1);
    far.pulse_line(2, 100, 900);
    far.clk_pulses(1'b0, 2);
    far.pulse_line(2, 100, 900);
    far.clk_pulses(1'b0, 2);
    repeat (4) @(posedge clk);
    chk(32'(cnt[0] - n), 32'h2);
    chk(32'(trg_cnt - m), 32'h2);
    bus(1'b0, 6'h14, 32'h0);
    chk(32'(q[2:0]), 32'h2);
    bus(1'b1, 6'h10, 32'h4);
    bus(1'b1, 6'h00, 32'h2);
    bus(1'b1, 6'h10, 32'h1);
    n = cnt[0];
    bus(1'b1, 6'h10, 32'h10);
    repeat (3) @(posedge clk);
    chk(32'(cnt[0] - n), 32'h1);
    bus(1'b1, 6'h10, 32'h4);
    bus(1'b1, 6'h00, 32'h4);
    bus(1'b1, 6'h10, 32'h1);
    far.pulse_line(2, 100, 900);
    repeat (3) @(posedge clk);
    chk(32'(cnt[0] - n), 32'h2);
    bus(1'b1, 6'h10, 32'h4);
    bus(1'b1, 6'h20, 32'hf);
    for (int i = 0; i < 4; i++) begin
      far.pulse_line(i, 80, 0);
      repeat (3) @(posedge clk);
      chk(32'(irq), 32'h1);
      bus(1'b0, 6'h24, 32'h0);
      chk(q, 32'h1 << i);
      bus(1'b1, 6'h24, 32'h1 << i);
      bus(1'b0, 6'h24, 32'h0);
      chk(32'({irq, q[3:0]}), 32'h0);
    end
    bus(1'b1, 6'h20, 32'h0);
    far.pulse_line(0, 80, 0);
    repeat (3) @(posedge clk);
    bus(1'b0, 6'h24, 32'h0);
    chk(32'({irq, q[3:0]}), 32'h0);
    bus(1'b1, 6'h20, 32'h8);
    far.pulse_line(3, 80, 0);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h1);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'({wait_req, t1o, t1e, t2o, t2e, irq, dout}), 32'h3e_0000);
    rstn <= 1'b1;
    bus(1'b0, 6'h00, 32'h0);
    chk(q, 32'h0);
    complete_run();
  end
endmodule : test_scte_top
`default_nettype wire
